// [hdl/rtcs_i2c_slave.sv]
`timescale 1ns/10ps
`include "rtcs_map.svh"
module rtcs_i2c_slave #(
	parameter int unsigned                OVR_STEPS   = `RTCS_OVR_STEPS,
	parameter logic [2*OVR_STEPS-1:0]     OVR_PATTERN = `RTCS_OVR_PATTERN,
	parameter int unsigned                OVR_MIN_CYC = `RTCS_OVR_STEP_CYC
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst_b,
	input  wire logic                     scl_in,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe,
	input  wire logic                     osc_running,
	input  wire logic                     override_permit_bit,
	input  wire logic [7:0]               reg_rdata,
	output logic      [3:0]               reg_addr,
	output rtcs_pkg::rtcs_wr_s            reg_wr,
	output logic                          reg_rd,
	output logic                          internal_reset,
	output logic                          override_mode,
	output logic                          bus_busy
);
	logic [2:0]            sync_q;
	logic                  scl_s;
	logic                  sda_s;
	logic                  osc_s;
	logic                  scl_p_reg;
	logic                  sda_p_reg;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_det;
	logic                  stop_det;
	logic                  byte_end;
	logic                  addr_hit;
	logic                  int_rst;
	logic                  ovr_enter;
	logic                  ovr_reg;
	logic                  busy_reg;
	logic                  mack_reg;
	logic [3:0]            cnt_reg;
	logic [7:0]            shift_reg;
	logic [7:0]            tx_reg;
	logic [3:0]            ptr_reg;
	rtcs_pkg::rtcs_state_e state_reg;
	rtcs_pkg::rtcs_lines_s lines;

	rtcs_sync #(
		.W       (3),
		.RST_VAL (`RTCS_SYNC_RST)
	) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        ({osc_running, sda_in, scl_in}),
		.q        (sync_q)
	);

	assign scl_s     = sync_q[0];
	assign sda_s     = sync_q[1];
	assign osc_s     = sync_q[2];
	assign lines     = '{scl: scl_s, sda: sda_s};

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_p_reg <= 1'b1;
			sda_p_reg <= 1'b1;
		end
		else
		begin
			scl_p_reg <= scl_s;
			sda_p_reg <= sda_s;
		end
	end

	// Clock is only ever sampled, never driven
	assign scl_rise  = scl_s & ~scl_p_reg;
	assign scl_fall  = ~scl_s & scl_p_reg;
	// Data moving under a high clock is a condition, not a bit
	assign start_det = scl_s & scl_p_reg & sda_p_reg & ~sda_s;
	assign stop_det  = scl_s & scl_p_reg & ~sda_p_reg & sda_s;
	assign byte_end  = scl_fall && cnt_reg == `RTCS_BYTE_BITS;
	assign addr_hit  = shift_reg[7:1] == `RTCS_SLV_ADDR;

	rtcs_por_ovr #(
		.STEPS   (OVR_STEPS),
		.PATTERN (OVR_PATTERN),
		.MIN_CYC (OVR_MIN_CYC)
	) u_ovr (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.arm      (int_rst & override_permit_bit),
		.lines    (lines),
		.enter    (ovr_enter)
	);

	// Permit at zero only vetoes the override, nothing else
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ovr_reg <= 1'b0;
		end
		else if (!override_permit_bit)
		begin
			ovr_reg <= 1'b0;
		end
		else if (ovr_enter)
		begin
			ovr_reg <= 1'b1;
		end
	end

	// Stopped oscillator holds reset unless overridden
	assign int_rst        = ~osc_s & ~ovr_reg;
	assign internal_reset = int_rst;
	assign override_mode  = ovr_reg;
	assign sda_out        = 1'b0;
	assign reg_addr       = ptr_reg;
	assign bus_busy       = busy_reg;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_reg <= 1'b0;
		end
		else if (int_rst || stop_det)
		begin
			busy_reg <= 1'b0;
		end
		else if (start_det)
		begin
			busy_reg <= 1'b1;
		end
	end

	// Protocol state; normal service resumes once reset lifts
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg <= rtcs_pkg::ST_IDLE;
			cnt_reg   <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg    <= 8'h00;
			mack_reg  <= 1'b0;
		end
		else if (int_rst)
		begin
			state_reg <= rtcs_pkg::ST_IDLE;
			cnt_reg   <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg    <= 8'h00;
			mack_reg  <= 1'b0;
		end
		else if (start_det)
		begin
			state_reg <= rtcs_pkg::ST_ADDR;
			cnt_reg   <= 4'h0;
		end
		else if (stop_det)
		begin
			state_reg <= rtcs_pkg::ST_IDLE;
		end
		else
		begin
			case (state_reg)
				rtcs_pkg::ST_ADDR,
				rtcs_pkg::ST_REG,
				rtcs_pkg::ST_WDATA:
				begin
					if (scl_rise)
					begin
						shift_reg <= {shift_reg[6:0], sda_s};
						cnt_reg   <= cnt_reg + 4'h1;
					end
					else if (byte_end)
					begin
						cnt_reg <= 4'h0;
						if (state_reg == rtcs_pkg::ST_ADDR)
						begin
							state_reg <= addr_hit ? rtcs_pkg::ST_ADDR_ACK : rtcs_pkg::ST_WAIT;
						end
						else if (state_reg == rtcs_pkg::ST_REG)
						begin
							state_reg <= rtcs_pkg::ST_REG_ACK;
						end
						else
						begin
							state_reg <= rtcs_pkg::ST_WACK;
						end
					end
				end
				rtcs_pkg::ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						if (shift_reg[0])
						begin
							state_reg <= rtcs_pkg::ST_RDATA;
							tx_reg    <= reg_rdata;
						end
						else
						begin
							state_reg <= rtcs_pkg::ST_REG;
						end
					end
				end
				rtcs_pkg::ST_REG_ACK,
				rtcs_pkg::ST_WACK:
				begin
					if (scl_fall)
					begin
						state_reg <= rtcs_pkg::ST_WDATA;
					end
				end
				rtcs_pkg::ST_RDATA:
				begin
					if (scl_rise)
					begin
						cnt_reg <= cnt_reg + 4'h1;
					end
					else if (byte_end)
					begin
						cnt_reg   <= 4'h0;
						state_reg <= rtcs_pkg::ST_RACK;
					end
					else if (scl_fall)
					begin
						tx_reg <= {tx_reg[6:0], 1'b0};
					end
				end
				rtcs_pkg::ST_RACK:
				begin
					if (scl_rise)
					begin
						mack_reg <= ~sda_s;
					end
					else if (scl_fall)
					begin
						if (mack_reg)
						begin
							state_reg <= rtcs_pkg::ST_RDATA;
							tx_reg    <= reg_rdata;
						end
						else
						begin
							state_reg <= rtcs_pkg::ST_WAIT;
						end
					end
				end
				rtcs_pkg::ST_IDLE,
				rtcs_pkg::ST_WAIT:
				begin
					cnt_reg <= 4'h0;
				end
				default:
				begin
					state_reg <= rtcs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Data line moves on clock falls, or is released at once by start, stop or internal reset
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sda_oe <= 1'b0;
		end
		else if (int_rst || start_det || stop_det)
		begin
			sda_oe <= 1'b0;
		end
		else if (scl_fall)
		begin
			case (state_reg)
				rtcs_pkg::ST_ADDR:     sda_oe <= byte_end & addr_hit;
				rtcs_pkg::ST_REG,
				rtcs_pkg::ST_WDATA:    sda_oe <= byte_end;
				rtcs_pkg::ST_ADDR_ACK: sda_oe <= shift_reg[0] & ~reg_rdata[7];
				rtcs_pkg::ST_RDATA:    sda_oe <= ~byte_end & ~tx_reg[6];
				rtcs_pkg::ST_RACK:     sda_oe <= mack_reg & ~reg_rdata[7];
				default:               sda_oe <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ptr_reg <= `RTCS_PTR_RST;
		end
		else if (int_rst)
		begin
			ptr_reg <= `RTCS_PTR_RST;
		end
		else if (byte_end && state_reg == rtcs_pkg::ST_REG)
		begin
			ptr_reg <= shift_reg[3:0];
		end
		else if (scl_fall && state_reg == rtcs_pkg::ST_WACK)
		begin
			ptr_reg <= ptr_reg + 4'h1;
		end
		else if (byte_end && state_reg == rtcs_pkg::ST_RDATA)
		begin
			ptr_reg <= ptr_reg + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_wr <= '0;
			reg_rd <= 1'b0;
		end
		else
		begin
			reg_wr.strobe <= ~int_rst & byte_end & (state_reg == rtcs_pkg::ST_WDATA);
			reg_wr.addr   <= ptr_reg;
			reg_wr.data   <= shift_reg;
			reg_rd        <= ~int_rst & scl_fall & ((state_reg == rtcs_pkg::ST_ADDR_ACK & shift_reg[0])
			                 | (state_reg == rtcs_pkg::ST_RACK & mack_reg));
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_override_release: assert property ((ovr_enter && override_permit_bit) |=> !int_rst ##1 !int_rst)
		else $error("override did not release reset");
	a_permit_clear: assert property (!override_permit_bit |=> !override_mode)
		else $error("override stayed with permit low");
	a_entry_blocked: assert property ((!override_permit_bit && !override_mode) |=> !override_mode)
		else $error("override entered while blocked");
	a_reset_quiet: assert property (int_rst |=> (state_reg == rtcs_pkg::ST_IDLE && ptr_reg == 4'h0 && !sda_oe))
		else $error("bus logic active in reset");
	a_start_seen: assert property ((start_det && !int_rst) |=> state_reg == rtcs_pkg::ST_ADDR && bus_busy)
		else $error("start not detected");
	a_stop_seen: assert property ((stop_det && !int_rst) |=> state_reg == rtcs_pkg::ST_IDLE && !sda_oe && !bus_busy)
		else $error("stop not detected");
	a_idle_release: assert property ((state_reg == rtcs_pkg::ST_IDLE || state_reg == rtcs_pkg::ST_WAIT) |-> !sda_oe)
		else $error("data driven while unaddressed");
	a_addr_ack: assert property ((byte_end && state_reg == rtcs_pkg::ST_ADDR && !int_rst && !start_det)
		|=> sda_oe == $past(addr_hit))
		else $error("address ack wrong");
	a_ptr_nibble: assert property ((byte_end && state_reg == rtcs_pkg::ST_REG && !int_rst)
		|=> ptr_reg == $past(shift_reg[3:0]))
		else $error("pointer not low nibble");
	a_write_ack: assert property ((byte_end && state_reg == rtcs_pkg::ST_WDATA && !int_rst)
		|=> reg_wr.strobe && sda_oe && reg_wr.addr == $past(ptr_reg))
		else $error("write byte not acked");
	a_ptr_incr: assert property ((scl_fall && state_reg == rtcs_pkg::ST_WACK && !int_rst)
		|=> ptr_reg == $past(ptr_reg) + 4'h1)
		else $error("pointer did not advance");
	a_nack_release: assert property ((scl_fall && state_reg == rtcs_pkg::ST_RACK && !mack_reg && !int_rst)
		|=> !sda_oe && state_reg == rtcs_pkg::ST_WAIT)
		else $error("data held after nack");
	a_ack_hold: assert property ((sda_oe && scl_rise) |-> ##1 sda_oe)
		else $error("data released on clock high");
endmodule : rtcs_i2c_slave

// [hdl/rtcs_map.svh]
`ifndef RTCS_MAP_SVH
`define RTCS_MAP_SVH
`define RTCS_CLK_PERIOD_NS 100
`define RTCS_OVR_STEP_NS   1000
`define RTCS_OVR_STEP_CYC  ((`RTCS_OVR_STEP_NS + `RTCS_CLK_PERIOD_NS - 1) / `RTCS_CLK_PERIOD_NS)
`define RTCS_OVR_STEPS     4
`define RTCS_OVR_PATTERN   8'hd2
`define RTCS_SLV_ADDR      7'h51
`define RTCS_BYTE_BITS     4'h8
`define RTCS_PTR_RST       4'h0
`define RTCS_SYNC_RST      3'h3
`endif

// [hdl/rtcs_pkg.sv]
package rtcs_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_REG,
		ST_REG_ACK,
		ST_WDATA,
		ST_WACK,
		ST_RDATA,
		ST_RACK,
		ST_WAIT
	} rtcs_state_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} rtcs_lines_s;

	typedef struct packed {
		logic       strobe;
		logic [3:0] addr;
		logic [7:0] data;
	} rtcs_wr_s;
endpackage : rtcs_pkg

// [hdl/rtcs_sync.sv]
`timescale 1ns/10ps
module rtcs_sync #(
	parameter int unsigned     W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_reg <= RST_VAL;
			q        <= RST_VAL;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : rtcs_sync

// [hdl/rtcs_por_ovr.sv]
`timescale 1ns/10ps
module rtcs_por_ovr #(
	parameter int unsigned          STEPS   = 4,
	parameter logic [2*STEPS-1:0]   PATTERN = '0,
	parameter int unsigned          MIN_CYC = 1
) (
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	input  wire logic               arm,
	input  rtcs_pkg::rtcs_lines_s   lines,
	output logic                    enter
);
	localparam int unsigned SW = $clog2(STEPS);
	localparam int unsigned CW = $clog2(MIN_CYC + 1);
	localparam logic [SW-1:0] LAST  = SW'(STEPS - 1);
	localparam logic [CW-1:0] MIN_C = CW'(MIN_CYC);
	localparam logic [CW-1:0] MIN_M = CW'(MIN_CYC - 1);

	logic [1:0]    pat [STEPS];
	logic [SW-1:0] step_reg;
	logic [SW-1:0] nxt_idx;
	logic [CW-1:0] cnt_reg;
	logic [1:0]    now;

	for (genvar i = 0; i < STEPS; i++)
	begin : g_pat
		assign pat[i] = PATTERN[2*i +: 2];
	end

	assign now     = lines;
	assign nxt_idx = (step_reg == LAST) ? step_reg : step_reg + SW'(1);

	// Each step must be held; any stray level restarts the walk
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			step_reg <= '0;
			cnt_reg  <= '0;
			enter    <= 1'b0;
		end
		else
		begin
			enter <= 1'b0;
			if (!arm)
			begin
				step_reg <= '0;
				cnt_reg  <= '0;
			end
			else if (now == pat[step_reg])
			begin
				if (step_reg == LAST && cnt_reg == MIN_M)
				begin
					enter    <= 1'b1;
					step_reg <= '0;
					cnt_reg  <= '0;
				end
				else if (cnt_reg != MIN_C)
				begin
					cnt_reg <= cnt_reg + CW'(1);
				end
			end
			else if (step_reg != LAST && now == pat[nxt_idx] && cnt_reg == MIN_C)
			begin
				step_reg <= nxt_idx;
				cnt_reg  <= CW'(1);
			end
			else
			begin
				step_reg <= '0;
				cnt_reg  <= (now == pat[0]) ? CW'(1) : '0;
			end
		end
	end
endmodule : rtcs_por_ovr

// [tb/rtcs_bus_master.sv]
`timescale 1ns/10ps
module rtcs_bus_master (
	input  wire logic core_clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_low
);
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	// Open drain: a released data line floats to the pull-up
	task automatic lines(input logic c, input logic d, input int n);
		scl <= c;
		sda_low <= ~d;
		tick(n);
	endtask : lines

	task automatic start();
		lines(1'b1, 1'b1, 4);
		lines(1'b1, 1'b0, 4);
		lines(1'b0, 1'b0, 2);
	endtask : start

	task automatic stop();
		lines(1'b0, 1'b0, 2);
		lines(1'b1, 1'b0, 4);
		lines(1'b1, 1'b1, 4);
	endtask : stop

	// Data moves mid low phase so it never changes while clock is high
	task automatic bits(input logic b, output logic s);
		lines(1'b0, b, 2);
		lines(1'b1, b, 4);
		s = sda_wire;
		lines(1'b0, b, 2);
	endtask : bits

	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			bits(tx[i], rx[i]);
		bits(mack, ack);
	endtask : xfer

	task automatic walk(input logic [7:0] pat, input int n);
		for (int i = 0; i < 4; i++)
			lines(pat[2*i+1], pat[2*i], n);
	endtask : walk
endmodule : rtcs_bus_master

// [tb/test_rtcs_i2c_slave.sv]
`timescale 1ns/10ps
`include "rtcs_map.svh"
module test_rtcs_i2c_slave;
	// Step hold above any bus phase (4 clocks), so traffic never walks the pattern
	localparam int unsigned MINC = 5;
	logic               core_clk;
	logic               rst_b;
	logic               osc_running;
	logic               override_permit_bit;
	logic               scl;
	logic               sda_low;
	logic               sda_wire;
	logic               sda_out;
	logic               sda_oe;
	logic [7:0]         reg_rdata;
	logic [3:0]         reg_addr;
	rtcs_pkg::rtcs_wr_s reg_wr;
	rtcs_pkg::rtcs_wr_s wr_last;
	logic               reg_rd;
	logic               internal_reset;
	logic               override_mode;
	logic               bus_busy;
	logic [7:0]         rx;
	logic               ack;
	int                 wr_cnt;
	int                 rd_cnt;
	int                 errors;
	int                 n_checks;

	assign sda_wire = !(sda_low || (sda_oe && !sda_out));
	assign reg_rdata = {4'ha, reg_addr};

	rtcs_i2c_slave #(.OVR_MIN_CYC(MINC)) rtcs_i2c_slave_i (
		.core_clk            (core_clk),
		.rst_b               (rst_b),
		.scl_in              (scl),
		.sda_in              (sda_wire),
		.sda_out             (sda_out),
		.sda_oe              (sda_oe),
		.osc_running         (osc_running),
		.override_permit_bit (override_permit_bit),
		.reg_rdata           (reg_rdata),
		.reg_addr            (reg_addr),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.internal_reset      (internal_reset),
		.override_mode       (override_mode),
		.bus_busy            (bus_busy)
	);

	rtcs_bus_master rtcs_bus_master_i (
		.core_clk (core_clk),
		.sda_wire (sda_wire),
		.scl      (scl),
		.sda_low  (sda_low)
	);

	always #50 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		if (reg_wr.strobe === 1'b1)
		begin
			wr_last <= reg_wr;
			wr_cnt  <= wr_cnt + 1;
		end
		if (reg_rd === 1'b1)
		begin
			rd_cnt <= rd_cnt + 1;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr_byte(input logic [7:0] b, input logic a);
		rtcs_bus_master_i.xfer(b, 1'b1, rx, ack);
		chk("ack", {7'h0, a}, {7'h0, ack});
	endtask : wr_byte

	task automatic rd_byte(input logic [7:0] exp, input logic mack);
		rtcs_bus_master_i.xfer(8'hff, mack, rx, ack);
		chk("rdata", exp, rx);
	endtask : rd_byte

	task automatic test_reset();
		chk("int_rst", 8'h1, {7'h0, internal_reset});
		chk("ptr", 8'h0, {4'h0, reg_addr});
		chk("sda_out", 8'h0, {7'h0, sda_out});
		rtcs_bus_master_i.start();
		wr_byte(8'ha2, 1'b1);
		rtcs_bus_master_i.stop();
		chk("ovr", 8'h0, {7'h0, override_mode});
		$display("test_reset done");
	endtask : test_reset

	task automatic test_override(input logic exp);
		rtcs_bus_master_i.walk(`RTCS_OVR_PATTERN, MINC + 6);
		tick(4);
		chk("ovr", {7'h0, exp}, {7'h0, override_mode});
		chk("int_rst", {7'h0, !exp}, {7'h0, internal_reset});
		$display("test_override done");
	endtask : test_override

	task automatic test_write();
		rtcs_bus_master_i.start();
		chk("busy", 8'h1, {7'h0, bus_busy});
		wr_byte(8'ha2, 1'b0);
		wr_byte(8'hf5, 1'b0);
		chk("ptr", 8'h5, {4'h0, reg_addr});
		wr_byte(8'h3c, 1'b0);
		chk("wdata", 8'h3c, wr_last.data);
		wr_byte(8'hc3, 1'b0);
		chk("waddr", 8'h6, {4'h0, wr_last.addr});
		chk("wdata", 8'hc3, wr_last.data);
		rtcs_bus_master_i.stop();
		chk("busy", 8'h0, {7'h0, bus_busy});
		chk("ptr", 8'h7, {4'h0, reg_addr});
		chk("rd_cnt", 8'h0, rd_cnt[7:0]);
		$display("test_write done");
	endtask : test_write

	task automatic test_bad();
		rtcs_bus_master_i.start();
		wr_byte(8'ha4, 1'b1);
		wr_byte(8'h00, 1'b1);
		rtcs_bus_master_i.stop();
		chk("wr_cnt", 8'h2, wr_cnt[7:0]);
		$display("test_bad done");
	endtask : test_bad

	task automatic test_permit();
		@(posedge core_clk) override_permit_bit <= 1'b0;
		tick(3);
		chk("ovr", 8'h0, {7'h0, override_mode});
		chk("ptr", 8'h0, {4'h0, reg_addr});
		test_override(1'b0);
		@(posedge core_clk) override_permit_bit <= 1'b1;
		test_override(1'b1);
		@(posedge core_clk) override_permit_bit <= 1'b0;
		osc_running <= 1'b1;
		tick(8);
		chk("int_rst", 8'h0, {7'h0, internal_reset});
		rtcs_bus_master_i.start();
		wr_byte(8'ha2, 1'b0);
		rtcs_bus_master_i.stop();
		$display("test_permit done");
	endtask : test_permit

	task automatic test_read();
		rtcs_bus_master_i.start();
		wr_byte(8'ha2, 1'b0);
		wr_byte(8'h0e, 1'b0);
		rtcs_bus_master_i.stop();
		rtcs_bus_master_i.start();
		wr_byte(8'ha3, 1'b0);
		rd_byte(8'hae, 1'b0);
		rd_byte(8'haf, 1'b1);
		tick(4);
		chk("sda", 8'h1, {7'h0, sda_wire});
		chk("ptr", 8'h0, {4'h0, reg_addr});
		chk("rd_cnt", 8'h2, rd_cnt[7:0]);
		rtcs_bus_master_i.stop();
		$display("test_read done");
	endtask : test_read

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	initial
	begin
		repeat (12000) @(posedge core_clk);
		errors++;
		stop_test();
	end

	initial
	begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		osc_running = 1'b0;
		override_permit_bit = 1'b1;
		wr_cnt = 0;
		rd_cnt = 0;
		errors = 0;
		n_checks = 0;
		tick(4);
		rst_b <= 1'b1;
		tick(4);
		test_reset();
		test_override(1'b1);
		test_write();
		test_bad();
		test_permit();
		test_read();
		stop_test();
	end
endmodule : test_rtcs_i2c_slave
